// file: design/osr_pkg.sv
// constants shared by the oscillator select and reference divider block
package osr_pkg;
   // register word addresses
   localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
   localparam logic [3:0] ADDR_REF_DIV = 4'h1;
   localparam logic [3:0] ADDR_REF_TRIM = 4'h2;
   localparam logic [3:0] ADDR_UNLOCK = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;

   // oscillator_control field positions, plus the reference trim field (TRIM_LSB)
   localparam int CUR_LSB = 12;
   localparam int NXT_LSB = 8;
   localparam int FREEZE_BIT = 7;
   localparam int PINFRZ_BIT = 6;
   localparam int PLLLOCK_BIT = 5;
   localparam int CF_BIT = 3;
   localparam int PRIKEEP_BIT = 2;
   localparam int SECKEEP_BIT = 1;
   localparam int REQ_BIT = 0;
   localparam int TRIM_LSB = 7;

   // source encodings
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [2:0] SRC_RSVD = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV = 3'h7;

   // unlock key pair
   localparam logic [15:0] KEY_FIRST = 16'h0046;
   localparam logic [15:0] KEY_SECOND = 16'h0057;

   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_FAIL = 2;

   // reset values
   localparam logic [3:0] FRC_POSTDIV_DEFAULT = 4'h2;
   localparam logic [14:0] REF_DIV_RESET = 15'h0000;
   localparam logic [8:0] REF_TRIM_RESET = 9'h000;

   // switch settling time
   localparam int CLK_PERIOD_NS = 8;
   localparam int SWITCH_TIME_NS = 200;
   localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [0:0] {
      OSR_IDLE = 1'b0,
      OSR_SWITCH = 1'b1
   } osr_sw_e;

   typedef enum logic [1:0] {
      OSR_KEY_NONE = 2'b00,
      OSR_KEY_HALF = 2'b01,
      OSR_KEY_OPEN = 2'b10
   } osr_key_e;
endpackage

// file: design/osr_top.sv
// oscillator source select, clock-switch sequencer and fractional reference divider
`timescale 1ns/1ps
module osr_top #(
   parameter int SWITCH_CYCLES = osr_pkg::SWITCH_CYCLES
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rd_data_o,
   // configuration settings
   input wire logic [2:0] startup_source_cfg_i,
   input wire logic one_way_pin_freeze_cfg_i,
   // oscillator monitors, asynchronous
   input wire logic clock_fail_i,
   input wire logic pll_lock_i,
   // reference base clock, same domain
   input wire logic ref_base_i,
   // outputs
   output logic [2:0] current_source_o,
   output logic switch_pending_o,
   output logic pin_map_freeze_o,
   output logic primary_osc_keep_on_o,
   output logic secondary_osc_keep_on_o,
   output logic pll_locked_o,
   output logic [3:0] frc_postdiv_o,
   output logic ref_clk_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      osr_pkg::osr_sw_e fsm;
      logic [7:0] sw_cnt;
      logic cfg_loaded;
      logic [2:0] cur;
      logic [2:0] nxt;
      logic freeze;
      logic pin_freeze;
      logic one_way;
      logic cf;
      logic pri_keep;
      logic sec_keep;
      logic req;
      logic pll_lock;
      logic [3:0] postdiv;
      logic [14:0] ref_div;
      logic [8:0] ref_trim;
      osr_pkg::osr_key_e key;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic [15:0] rd_data;
      logic [2:0] fail_sync;
      logic [2:0] lock_sync;
      logic fail_f;
      logic lock_f;
      logic base_prev;
      logic [14:0] ref_cnt;
      logic [8:0] ref_acc;
      logic ref_carry;
      logic ref_out;
   } osr_state_s;

   function automatic logic osr_is_pll(input logic [2:0] src);
      osr_is_pll = (src == osr_pkg::SRC_FRC_PLL) || (src == osr_pkg::SRC_PRI_PLL);
   endfunction

   osr_state_s s;
   osr_state_s next_s;
   logic wr_osc;
   logic [2:0] ev;
   logic [9:0] trim_sum;
   logic [15:0] ref_target;
   logic [14:0] cnt_inc;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      ev = 3'h0;
      trim_sum = {1'b0, s.ref_acc} + {1'b0, s.ref_trim};
      ref_target = {1'b0, s.ref_div} + {15'h0000, s.ref_carry};
      cnt_inc = s.ref_cnt + 15'h0001;
      wr_osc = wr_i && (addr_i == osr_pkg::ADDR_OSC_CTRL) && (s.key == osr_pkg::OSR_KEY_OPEN);

      // strap capture one cycle after release, never under the async reset
      if (!s.cfg_loaded) begin
         next_s.cfg_loaded = 1'b1;
         next_s.nxt = startup_source_cfg_i;
         next_s.cur = startup_source_cfg_i;
         next_s.one_way = one_way_pin_freeze_cfg_i;
      end

      // three-stage sync, a change counts once stages two and three agree
      next_s.fail_sync = {s.fail_sync[1:0], clock_fail_i};
      next_s.lock_sync = {s.lock_sync[1:0], pll_lock_i};
      if (s.fail_sync[1] == s.fail_sync[2]) begin
         next_s.fail_f = s.fail_sync[2];
      end
      if (s.lock_sync[1] == s.lock_sync[2]) begin
         next_s.lock_f = s.lock_sync[2];
      end

      // unlock key: any write other than the expected key closes it
      if (wr_i) begin
         if (addr_i == osr_pkg::ADDR_UNLOCK && wr_data_i == osr_pkg::KEY_FIRST) begin
            next_s.key = osr_pkg::OSR_KEY_HALF;
         end else if (addr_i == osr_pkg::ADDR_UNLOCK && wr_data_i == osr_pkg::KEY_SECOND &&
                      s.key == osr_pkg::OSR_KEY_HALF) begin
            next_s.key = osr_pkg::OSR_KEY_OPEN;
         end else begin
            next_s.key = osr_pkg::OSR_KEY_NONE;
         end
      end

      // oscillator control writes
      if (wr_osc) begin
         if (!s.freeze) begin
            next_s.nxt = wr_data_i[osr_pkg::NXT_LSB +: 3];
            if (wr_data_i[osr_pkg::REQ_BIT]) begin
               next_s.req = 1'b1;
            end
         end
         if (wr_data_i[osr_pkg::FREEZE_BIT]) begin
            next_s.freeze = 1'b1;
         end
         if (!(s.one_way && s.pin_freeze)) begin
            next_s.pin_freeze = wr_data_i[osr_pkg::PINFRZ_BIT];
         end
         if (!wr_data_i[osr_pkg::CF_BIT]) begin
            next_s.cf = 1'b0;
         end
         next_s.pri_keep = wr_data_i[osr_pkg::PRIKEEP_BIT];
         next_s.sec_keep = wr_data_i[osr_pkg::SECKEEP_BIT];
      end
      if (wr_i && addr_i == osr_pkg::ADDR_REF_DIV) begin
         next_s.ref_div = wr_data_i[14:0];
      end
      if (wr_i && addr_i == osr_pkg::ADDR_REF_TRIM) begin
         next_s.ref_trim = wr_data_i[osr_pkg::TRIM_LSB +: 9];
      end
      if (wr_i && addr_i == osr_pkg::ADDR_IRQ_MASK) begin
         next_s.irq_mask = wr_data_i[2:0];
      end

      // clock fail: hardware set after the clear so the set wins
      if (s.fail_f) begin
         next_s.cf = 1'b1;
         ev[osr_pkg::IRQ_FAIL] = 1'b1;
      end

      // switch sequencer
      case (s.fsm)
         osr_pkg::OSR_IDLE: begin
            if (s.req) begin
               if (s.nxt == osr_pkg::SRC_RSVD) begin
                  next_s.req = 1'b0;
                  ev[osr_pkg::IRQ_ABORT] = 1'b1;
               end else begin
                  next_s.fsm = osr_pkg::OSR_SWITCH;
                  next_s.sw_cnt = 8'(SWITCH_CYCLES - 1);
               end
            end
         end
         osr_pkg::OSR_SWITCH: begin
            if (s.sw_cnt == 8'h00) begin
               next_s.fsm = osr_pkg::OSR_IDLE;
               next_s.cur = s.nxt;
               next_s.req = 1'b0;
               ev[osr_pkg::IRQ_DONE] = 1'b1;
            end else begin
               next_s.sw_cnt = s.sw_cnt - 8'h01;
            end
         end
         default: begin
            next_s.fsm = osr_pkg::OSR_IDLE;
         end
      endcase

      // lock reads zero while switching or without pll
      next_s.pll_lock = s.lock_f && osr_is_pll(next_s.cur) && (next_s.fsm == osr_pkg::OSR_IDLE);
      next_s.postdiv = osr_pkg::FRC_POSTDIV_DEFAULT;

      // reference divider counts base rising edges; fraction stretches some half periods
      next_s.base_prev = ref_base_i;
      if (s.ref_div == 15'h0000) begin
         next_s.ref_out = ref_base_i;
         next_s.ref_cnt = 15'h0000;
      end else if (ref_base_i && !s.base_prev) begin
         if ({1'b0, cnt_inc} >= ref_target) begin
            next_s.ref_cnt = 15'h0000;
            next_s.ref_out = !s.ref_out;
            next_s.ref_acc = trim_sum[8:0];
            next_s.ref_carry = trim_sum[9];
         end else begin
            next_s.ref_cnt = cnt_inc;
         end
      end

      // interrupt status: write one clears, new events win
      if (wr_i && addr_i == osr_pkg::ADDR_IRQ_STAT) begin
         next_s.irq_stat = s.irq_stat & ~wr_data_i[2:0];
      end
      next_s.irq_stat = next_s.irq_stat | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

      // read data one cycle after the strobe, zero otherwise
      next_s.rd_data = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            osr_pkg::ADDR_OSC_CTRL: begin
               next_s.rd_data[osr_pkg::CUR_LSB +: 3] = s.cur;
               next_s.rd_data[osr_pkg::NXT_LSB +: 3] = s.nxt;
               next_s.rd_data[osr_pkg::FREEZE_BIT] = s.freeze;
               next_s.rd_data[osr_pkg::PINFRZ_BIT] = s.pin_freeze;
               next_s.rd_data[osr_pkg::PLLLOCK_BIT] = s.pll_lock;
               next_s.rd_data[osr_pkg::CF_BIT] = s.cf;
               next_s.rd_data[osr_pkg::PRIKEEP_BIT] = s.pri_keep;
               next_s.rd_data[osr_pkg::SECKEEP_BIT] = s.sec_keep;
               next_s.rd_data[osr_pkg::REQ_BIT] = s.req;
            end
            osr_pkg::ADDR_REF_DIV: begin
               next_s.rd_data[14:0] = s.ref_div;
            end
            osr_pkg::ADDR_REF_TRIM: begin
               next_s.rd_data[osr_pkg::TRIM_LSB +: 9] = s.ref_trim;
            end
            osr_pkg::ADDR_UNLOCK: begin
               next_s.rd_data[1:0] = s.key;
            end
            osr_pkg::ADDR_IRQ_STAT: begin
               next_s.rd_data[2:0] = s.irq_stat;
            end
            osr_pkg::ADDR_IRQ_MASK: begin
               next_s.rd_data[2:0] = s.irq_mask;
            end
            default: begin
               next_s.rd_data = 16'h0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
         s.fsm <= osr_pkg::OSR_IDLE;
         s.key <= osr_pkg::OSR_KEY_NONE;
         s.postdiv <= osr_pkg::FRC_POSTDIV_DEFAULT;
         s.ref_div <= osr_pkg::REF_DIV_RESET;
         s.ref_trim <= osr_pkg::REF_TRIM_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rd_data;
   assign current_source_o = s.cur;
   assign switch_pending_o = s.req;
   assign pin_map_freeze_o = s.pin_freeze;
   assign primary_osc_keep_on_o = s.pri_keep;
   assign secondary_osc_keep_on_o = s.sec_keep;
   assign pll_locked_o = s.pll_lock;
   assign frc_postdiv_o = s.postdiv;
   assign ref_clk_o = s.ref_out;
   assign irq_o = s.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence osc_write_locked;
      wr_i && addr_i == osr_pkg::ADDR_OSC_CTRL && s.key != osr_pkg::OSR_KEY_OPEN;
   endsequence

   sequence switch_started;
      $rose(s.fsm == osr_pkg::OSR_SWITCH);
   endsequence

   // the strap load itself also moves cur, so only look once it is done
   cur_readonly_a: assert property ($past(s.cfg_loaded) && $changed(s.cur) |-> $past(s.fsm) == osr_pkg::OSR_SWITCH)
      else $error("current source changed outside a switch");
   next_locked_a: assert property (osc_write_locked ##0 s.cfg_loaded |=> $stable(s.nxt))
      else $error("next source changed without unlock");
   rsvd_abort_a: assert property (s.fsm == osr_pkg::OSR_IDLE && s.req && s.nxt == osr_pkg::SRC_RSVD
                                  |=> !s.req && s.fsm == osr_pkg::OSR_IDLE && s.irq_stat[osr_pkg::IRQ_ABORT])
      else $error("reserved source not refused");
   strap_load_a: assert property (!s.cfg_loaded |=> s.nxt == $past(startup_source_cfg_i))
      else $error("next source not loaded from startup setting");
   freeze_sticky_a: assert property (s.freeze |=> s.freeze)
      else $error("freeze bit cleared");
   fail_set_wins_a: assert property (s.fail_f |=> s.cf)
      else $error("clock fail lost");
   pll_zero_a: assert property (s.fsm == osr_pkg::OSR_SWITCH || !osr_is_pll(s.cur) |-> !s.pll_lock)
      else $error("pll lock shown while switching or without pll");
   pin_one_way_a: assert property (s.one_way && s.pin_freeze |=> s.pin_freeze)
      else $error("pin map freeze cleared in one-way mode");
   lock_guard_a: assert property (osc_write_locked |=> $stable(s.freeze) && $stable(s.pin_freeze))
      else $error("locked write changed control bits");
   postdiv_a: assert property (frc_postdiv_o == osr_pkg::FRC_POSTDIV_DEFAULT)
      else $error("postscaler not divide by two");
   bypass_a: assert property (s.ref_div == 15'h0000 && $past(s.ref_div) == 15'h0000 |=> ref_clk_o == $past(ref_base_i))
      else $error("undivided path broken");
   ref_cnt_a: assert property (s.ref_div != 15'h0000 |-> {1'b0, s.ref_cnt} <= {1'b0, s.ref_div})
      else $error("reference count past divisor");
   frac_zero_a: assert property (s.ref_trim == 9'h000 && !s.ref_carry |=> !s.ref_carry)
      else $error("fraction added with zero trim");
   // two cycles of request hold only for SWITCH_CYCLES of two or more
   switch_done_a: assert property (switch_started |-> s.req [*2] ##[1:300] (!s.req && s.irq_stat[osr_pkg::IRQ_DONE]))
      else $error("switch did not complete and clear request");
   freeze_next_a: assert property (s.freeze && s.cfg_loaded |=> $stable(s.nxt))
      else $error("next source changed while frozen");
   cf_clear_a: assert property (wr_osc && !wr_data_i[osr_pkg::CF_BIT] && !s.fail_f |=> !s.cf)
      else $error("clock fail not cleared by software");
   req_locked_a: assert property (osc_write_locked ##0 !s.req |=> !s.req)
      else $error("locked write raised a switch request");
   irq_level_a: assert property (irq_o == |(s.irq_stat & s.irq_mask))
      else $error("interrupt level differs from masked status");
   rd_idle_zero_a: assert property (!rd_i |=> rd_data_o == 16'h0000)
      else $error("read data shown without a read");
   unimpl_zero_a: assert property (rd_i && addr_i == osr_pkg::ADDR_REF_DIV |=> !rd_data_o[15])
      else $error("unimplemented bit reads one");
endmodule

// file: testbench/osr_top_tb_top.sv
// self-checking bench for the oscillator select and reference divider block
`timescale 1ns/1ps
module osr_top_tb_top;
   logic clock_i, rst_i, wr_i, rd_i, one_way_pin_freeze_cfg_i, clock_fail_i, pll_lock_i;
   logic ref_base_i = 1'b0;
   logic [3:0] addr_i;
   logic [15:0] wr_data_i;
   logic [2:0] startup_source_cfg_i;
   logic [15:0] rd_data_o;
   logic [2:0] current_source_o;
   logic switch_pending_o, pin_map_freeze_o, pll_locked_o, ref_clk_o, irq_o;
   logic primary_osc_keep_on_o, secondary_osc_keep_on_o;
   logic [3:0] frc_postdiv_o;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;

   osr_top #(.SWITCH_CYCLES(6)) osr_top_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
      .startup_source_cfg_i(startup_source_cfg_i), .one_way_pin_freeze_cfg_i(one_way_pin_freeze_cfg_i),
      .clock_fail_i(clock_fail_i), .pll_lock_i(pll_lock_i), .ref_base_i(ref_base_i),
      .current_source_o(current_source_o), .switch_pending_o(switch_pending_o),
      .pin_map_freeze_o(pin_map_freeze_o), .primary_osc_keep_on_o(primary_osc_keep_on_o),
      .secondary_osc_keep_on_o(secondary_osc_keep_on_o),
      .pll_locked_o(pll_locked_o), .frc_postdiv_o(frc_postdiv_o), .ref_clk_o(ref_clk_o), .irq_o(irq_o));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // free-running base input, rising every second clock
   always @(posedge clock_i) begin
      ref_base_i <= ~ref_base_i;
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("timeout after %0d cycles", cycles);
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checked %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask
   task automatic unlock();
      // software side of the unlock sequence
      wr(osr_pkg::ADDR_UNLOCK, osr_pkg::KEY_FIRST);
      wr(osr_pkg::ADDR_UNLOCK, osr_pkg::KEY_SECOND);
   endtask
   task automatic do_reset(input logic [2:0] cfg, input logic one_way);
      @(posedge clock_i);
      startup_source_cfg_i <= cfg;
      one_way_pin_freeze_cfg_i <= one_way;
      rst_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
   endtask
   // write 16-bit word then settle two cycles for the registered irq
   task automatic wr_settle(input logic [3:0] a, input logic [15:0] d);
      wr(a, d);
      repeat (2) @(posedge clock_i);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_lock();
      logic [15:0] d;
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("ctrl after reset", 16'h7700, d);
      chk("postscaler", 16'h0002, 16'(frc_postdiv_o));
      rd(osr_pkg::ADDR_REF_DIV, d);
      chk("divisor reset", 16'h0000, d);
      rd(4'hF, d);
      chk("unmapped read", 16'h0000, d);
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0201);
      unlock();
      wr(osr_pkg::ADDR_IRQ_MASK, 16'h0000);
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0201);
      #1 chk("locked request", 16'h0000, 16'(switch_pending_o));
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("locked ctrl", 16'h7700, d);
      $display("reset and lock test done");
   endtask
   task automatic t_switch();
      logic [2:0] codes [0:6] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
      logic [15:0] d;
      int n;
      wr(osr_pkg::ADDR_IRQ_MASK, 16'h0007);
      foreach (codes[i]) begin
         unlock();
         wr(osr_pkg::ADDR_OSC_CTRL, {5'h00, codes[i], 8'h01});
         #1 chk("pending", 16'h0001, 16'(switch_pending_o));
         repeat (3) @(posedge clock_i);
         #1 chk("pll while switching", 16'h0000, 16'(pll_locked_o));
         n = 0;
         while (switch_pending_o !== 1'b0 && n < 100) begin
            @(posedge clock_i);
            #1 n++;
         end
         chk("current source", 16'(codes[i]), 16'(current_source_o));
         rd(osr_pkg::ADDR_OSC_CTRL, d);
         chk("next source", 16'(codes[i]), 16'(d[10:8]));
         repeat (6) @(posedge clock_i);
         #1 chk("pll locked", 16'(codes[i] == 3'h1 || codes[i] == 3'h3), 16'(pll_locked_o));
         chk("irq raised", 16'h0001, 16'(irq_o));
         rd(osr_pkg::ADDR_IRQ_STAT, d);
         chk("done status", 16'h0001, d);
         wr_settle(osr_pkg::ADDR_IRQ_STAT, 16'h0001);
         chk("irq cleared", 16'h0000, 16'(irq_o));
      end
      // reserved code aborts with the mask closed first
      wr(osr_pkg::ADDR_IRQ_MASK, 16'h0000);
      unlock();
      wr_settle(osr_pkg::ADDR_OSC_CTRL, 16'h0601);
      repeat (20) @(posedge clock_i);
      #1 chk("reserved source", 16'h0007, 16'(current_source_o));
      chk("reserved pending", 16'h0000, 16'(switch_pending_o));
      chk("masked irq", 16'h0000, 16'(irq_o));
      wr_settle(osr_pkg::ADDR_IRQ_MASK, 16'h0002);
      chk("abort irq", 16'h0001, 16'(irq_o));
      wr_settle(osr_pkg::ADDR_IRQ_STAT, 16'h0002);
      chk("abort irq cleared", 16'h0000, 16'(irq_o));
      $display("switch test done");
   endtask
   task automatic t_fail();
      logic [15:0] d;
      wr(osr_pkg::ADDR_IRQ_MASK, 16'h0004);
      clock_fail_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      clock_fail_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("fail flag set", 16'h0001, 16'(d[3]));
      chk("fail irq", 16'h0001, 16'(irq_o));
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0700);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("fail flag cleared", 16'h0000, 16'(d[3]));
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0708);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("fail flag not settable", 16'h0000, 16'(d[3]));
      wr_settle(osr_pkg::ADDR_IRQ_STAT, 16'h0004);
      chk("fail irq cleared", 16'h0000, 16'(irq_o));
      $display("clock fail test done");
   endtask
   // cycles from one rising edge of the reference output to the next
   task automatic meas(output int p);
      logic last;
      for (int k = 0; k < 3; k++) begin
         p = 0;
         do begin
            last = ref_clk_o;
            @(posedge clock_i);
            #1 p++;
         end while (!(ref_clk_o === 1'b1 && last === 1'b0) && p < 300);
      end
   endtask
   task automatic t_ref();
      logic [15:0] d;
      logic b;
      int p;
      wr(osr_pkg::ADDR_REF_DIV, 16'hFFFF);
      rd(osr_pkg::ADDR_REF_DIV, d);
      chk("divisor width", 16'h7FFF, d);
      wr(osr_pkg::ADDR_REF_TRIM, 16'hFFFF);
      rd(osr_pkg::ADDR_REF_TRIM, d);
      chk("trim width", 16'hFF80, d);
      wr(osr_pkg::ADDR_REF_TRIM, 16'h0000);
      wr(osr_pkg::ADDR_REF_DIV, 16'h0000);
      repeat (2) @(posedge clock_i);
      repeat (6) begin
         @(posedge clock_i);
         b = ref_base_i;
         #1 chk("pass through", 16'(b), 16'(ref_clk_o));
      end
      // base period is two clocks: output period is 2 * (2 * div + 2 * trim / 512)
      wr(osr_pkg::ADDR_REF_DIV, 16'h0002);
      meas(p);
      chk("divide by four", 16'd8, 16'(p));
      wr(osr_pkg::ADDR_REF_TRIM, 16'h8000);
      meas(p);
      chk("divide with half", 16'd10, 16'(p));
      $display("reference divider test done");
   endtask
   task automatic t_freeze();
      logic [15:0] d;
      do_reset(osr_pkg::SRC_PRI, 1'b1);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("startup primary", 16'h2200, d);
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h02C0);
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0401);
      #1 chk("frozen request", 16'h0000, 16'(switch_pending_o));
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("frozen ctrl", 16'h22C0, d);
      chk("pin freeze kept", 16'h0001, 16'(pin_map_freeze_o));
      do_reset(osr_pkg::SRC_LOW_POWER_RC_OSC, 1'b0);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("freeze after reset", 16'h5500, d);
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0540);
      #1 chk("pin freeze set", 16'h0001, 16'(pin_map_freeze_o));
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0500);
      #1 chk("pin freeze cleared", 16'h0000, 16'(pin_map_freeze_o));
      unlock();
      wr(osr_pkg::ADDR_OSC_CTRL, 16'h0506);
      rd(osr_pkg::ADDR_OSC_CTRL, d);
      chk("keep on bits", 16'h5506, d);
      chk("keep on pins", 16'h0003, {14'h0000, primary_osc_keep_on_o, secondary_osc_keep_on_o});
      $display("freeze test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wr_data_i = 16'h0000;
      startup_source_cfg_i = osr_pkg::SRC_FRC_DIV;
      one_way_pin_freeze_cfg_i = 1'b1;
      clock_fail_i = 1'b0;
      pll_lock_i = 1'b1;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      t_reset_lock();
      t_switch();
      t_fail();
      t_ref();
      t_freeze();
      end_sim();
   end
endmodule
